// file: tb/mmd_cpu_model.sv
// Behavioural model of the fetch and data pipelines that issue requests.
`timescale 1ns/1ps
module mmd_cpu_model
  import mmd_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rstn,
  input  wire mmd_req_t f_cmd,
  input  wire mmd_req_t d_cmd,
  output mmd_req_t      fetch_req,
  output mmd_req_t      data_req
);
  mmd_req_t f_last;
  mmd_req_t d_last;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      f_last <= '0;
    else if (f_cmd.valid)
      f_last <= f_cmd;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      d_last <= '0;
    else if (d_cmd.valid)
      d_last <= d_cmd;
  end
  // Idle fields show the inverse of the last request so stale values are never mistaken.
  assign fetch_req = (rstn && f_cmd.valid) ? f_cmd : {1'b0, ~f_last[46:0]};
  assign data_req = (rstn && d_cmd.valid) ? d_cmd : {1'b0, ~d_last[46:0]};
endmodule : mmd_cpu_model

// file: tb/mmd_props.sv
// Concurrent checks on the ports of the memory map decoder.
`timescale 1ns/1ps
module mmd_props
  import mmd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire mmd_req_t    fetch_req,
  input wire mmd_req_t    data_req,
  input wire logic [14:0] wprot_size,
  input wire logic        reg_bank_access,
  input wire mmd_route_t  fetch_route,
  input wire mmd_route_t  data_route,
  input wire mmd_route_t  bus_to_data,
  input wire mmd_route_t  bus_to_fetch,
  input wire logic [7:0]  data_segment,
  input wire logic [1:0]  data_page,
  input wire logic        access_trap
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [23:0] da;
  logic [23:0] fa;
  logic [14:0] fofs;
  logic        hit_trap;
  logic        d_data_ram;
  logic        d_dport;
  logic        d_extio;
  logic        f_prog_ram;
  logic        d_cross;
  logic        d_word;
  logic        d_alt_can;
  logic        d_alt_ser;
  logic        d_rsv_wr;
  assign da = data_req.addr;
  assign fa = fetch_req.addr;
  assign fofs = fa[14:0];
  assign hit_trap = data_req.valid && da >= TRAP_BASE && da <= TRAP_END
                    || fetch_req.valid && fa >= TRAP_BASE && fa <= TRAP_END;
  assign d_data_ram = data_req.valid && da >= DATA_RAM_BASE && da <= DATA_RAM_END;
  assign d_dport = data_req.valid && da >= DPORT_BASE && da <= DPORT_END;
  assign d_extio = data_req.valid && da >= EXTIO_BASE && da <= EXTIO_END;
  assign f_prog_ram = fetch_req.valid && fa >= PROG_RAM_BASE && fa <= PROG_RAM_END;
  assign d_cross = data_req.valid && da >= PROG_RAM_BASE && da <= PROG_RAM_END;
  assign d_word = data_req.valid && data_req.size == MMD_SZ_WORD;
  assign d_alt_can = data_req.valid && da >= ALT_BASE && da < ALT_BASE + ALT_SER_OFS;
  assign d_alt_ser = data_req.valid && da >= ALT_BASE + ALT_SER_OFS && da <= ALT_END;
  assign d_rsv_wr = data_req.valid && data_req.write && da >= FLASH_RSV_LO
                    && da <= FLASH_RSV_HI;

  AST_FIELDS: assert property ($past(rstn) |->
    {data_segment, data_page} == $past(da[23:14])) else $error("segment or page wrong");
  AST_DVALID: assert property ($past(rstn) |->
    data_route.valid == $past(data_req.valid)) else $error("data route valid wrong");
  AST_FVALID: assert property ($past(rstn) |->
    fetch_route.valid == $past(fetch_req.valid)) else $error("fetch route valid wrong");
  AST_TRAP: assert property ($past(rstn) |->
    access_trap == $past(hit_trap)) else $error("trap flag wrong");
  AST_DATA_RAM: assert property ($past(rstn) && $past(d_data_ram) |->
    data_route.region == MMD_RG_DATA_RAM && data_route.taddr == $past(da) - DATA_RAM_BASE)
    else $error("data sram decode wrong");
  AST_DPORT: assert property ($past(rstn) && $past(d_dport) |->
    data_route.region == MMD_RG_DPORT) else $error("dual port ram decode wrong");
  AST_ORDER: assert property ($past(rstn) && $past(d_extio) |->
    data_route.ordered && data_route.region == MMD_RG_EXT_IO) else $error("io order wrong");
  AST_MIRROR: assert property ($past(rstn) && $past(f_prog_ram) |->
    fetch_route.region == MMD_RG_PROG_RAM && fetch_route.taddr[14:0] == $past(fofs))
    else $error("program sram mirror wrong");
  AST_ALT_CAN: assert property ($past(rstn) && $past(d_alt_can) |->
    data_route.region == MMD_RG_CAN && data_route.taddr == $past(da) - ALT_BASE + CAN_BASE)
    else $error("alternate can window wrong");
  AST_ALT_SER: assert property ($past(rstn) && $past(d_alt_ser) |->
    data_route.region == MMD_RG_SERIAL
    && data_route.taddr == $past(da) - ALT_BASE - ALT_SER_OFS + SER_BASE)
    else $error("alternate serial window wrong");
  AST_RSV_WR: assert property ($past(rstn) && $past(d_rsv_wr) |->
    data_route.wr_blocked && data_route.region == MMD_RG_FLASH_RSV)
    else $error("reserved flash write not blocked");
  AST_CROSS: assert property ($past(rstn) && $past(d_cross) |->
    bus_to_fetch.valid) else $error("no system bus crossing");
  AST_WORD: assert property ($past(rstn) && $past(d_word) |->
    data_route.byte_en == 2'h3) else $error("word byte enables wrong");
  AST_EMPTY: assert property (data_route.valid && data_route.region == MMD_RG_EMPTY |->
    data_route.zero_read && (data_route.wr_blocked || !data_route.write))
    else $error("empty region not zero");

  cover property (access_trap);
  cover property (bus_to_fetch.valid && fetch_route.valid);
  cover property (data_route.valid && data_route.wr_blocked);
  cover property (bus_to_data.valid && bus_to_fetch.valid);
endmodule : mmd_props

// file: tb/tb.sv
// Self-checking testbench of the memory map decoder.
`timescale 1ns/1ps
module tb;
  import mmd_pkg::*;
  typedef struct packed {
    logic [1:0]  fw;
    logic [23:0] a;
    mmd_region_t rg;
    logic [1:0]  bz;
  } mmd_row_t;
  logic        clk;
  logic        rstn;
  mmd_req_t    f_cmd;
  mmd_req_t    d_cmd;
  mmd_req_t    fetch_req;
  mmd_req_t    data_req;
  logic [14:0] wprot_size;
  logic        reg_bank_access;
  mmd_route_t  fetch_route;
  mmd_route_t  data_route;
  mmd_route_t  bus_to_data;
  mmd_route_t  bus_to_fetch;
  logic [7:0]  data_segment;
  logic [1:0]  data_page;
  logic        access_trap;
  int          error_cnt;
  int          n_compared;
  mmd_route_t  r;
  mmd_row_t    rows [22];

  mmd_cpu_model mmd_cpu_model_inst (.clk(clk), .rstn(rstn), .f_cmd(f_cmd), .d_cmd(d_cmd),
    .fetch_req(fetch_req), .data_req(data_req));
  mmd_memory_map_decoder mmd_memory_map_decoder_inst (.clk(clk), .rstn(rstn),
    .fetch_req(fetch_req), .data_req(data_req), .wprot_size(wprot_size),
    .reg_bank_access(reg_bank_access), .fetch_route(fetch_route), .data_route(data_route),
    .bus_to_data(bus_to_data), .bus_to_fetch(bus_to_fetch), .data_segment(data_segment),
    .data_page(data_page), .access_trap(access_trap));

  function automatic mmd_req_t mk(input logic w, input mmd_size_t sz, input logic [23:0] a);
    return '{1'b1, w, sz, 4'h0, a, 16'h0000};
  endfunction : mk

  task automatic go(input mmd_req_t qf, input mmd_req_t qd);
    f_cmd = qf;
    d_cmd = qd;
    @(posedge clk);
    #1;
  endtask : go

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    rows = '{'{2'h0, 24'h00A004, MMD_RG_DATA_RAM, 2'h0}, '{2'h0, 24'h00F600, MMD_RG_DPORT, 2'h0},
      '{2'h0, 24'h00FE00, MMD_RG_PRIM_REG, 2'h0}, '{2'h0, 24'h00F000, MMD_RG_EXTD_REG, 2'h0},
      '{2'h0, 24'h00E000, MMD_RG_XTRN_REG, 2'h0}, '{2'h0, 24'h008000, MMD_RG_EMPTY, 2'h1},
      '{2'h1, 24'h00F200, MMD_RG_EMPTY, 2'h3}, '{2'h0, 24'h001000, MMD_RG_EXT_MEM, 2'h0},
      '{2'h0, 24'h200000, MMD_RG_CAN, 2'h0}, '{2'h0, 24'h204000, MMD_RG_SERIAL, 2'h0},
      '{2'h0, 24'h208000, MMD_RG_CAN, 2'h0}, '{2'h0, 24'h20A000, MMD_RG_SERIAL, 2'h0},
      '{2'h0, 24'h210000, MMD_RG_EXT_IO, 2'h0}, '{2'h2, 24'hC00000, MMD_RG_FLASH, 2'h0},
      '{2'h1, 24'hC0F000, MMD_RG_FLASH_RSV, 2'h2}, '{2'h2, 24'hE08010, MMD_RG_PROG_RAM, 2'h0},
      '{2'h1, 24'hE00010, MMD_RG_PROG_RAM, 2'h2}, '{2'h1, 24'hE00200, MMD_RG_PROG_RAM, 2'h0},
      '{2'h2, 24'hF00000, MMD_RG_TRAP, 2'h1}, '{2'h0, 24'hFFFF00, MMD_RG_PBUS, 2'h0},
      '{2'h2, 24'hE80000, MMD_RG_EMU_RAM, 2'h0}, '{2'h0, 24'h20C000, MMD_RG_EMPTY, 2'h1}};
    error_cnt = 0;
    n_compared = 0;
    f_cmd = '0;
    d_cmd = '0;
    wprot_size = 15'h0100;
    reg_bank_access = 1'b0;
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].fw[1])
        go(mk(rows[i].fw[0], MMD_SZ_WORD, rows[i].a), '0);
      else
        go('0, mk(rows[i].fw[0], MMD_SZ_WORD, rows[i].a));
      r = rows[i].fw[1] ? fetch_route : data_route;
      chk("region", r.region, rows[i].rg);
      chk("blocked_zero", {r.wr_blocked, r.zero_read}, rows[i].bz);
      chk("trap", access_trap, rows[i].rg == MMD_RG_TRAP);
      if (!rows[i].fw[1])
        chk("segment", data_segment, rows[i].a[23:16]);
    end
    $display("Test decode table done");
    go(mk(1'b0, MMD_SZ_WORD, 24'h400000), mk(1'b1, MMD_SZ_WORD, 24'hE00300));
    chk("both_valid", {fetch_route.valid, data_route.valid}, 2'h3);
    chk("to_data", bus_to_data.valid, 1'b1);
    chk("to_fetch", bus_to_fetch.valid, 1'b1);
    go('0, mk(1'b0, MMD_SZ_BYTE, 24'h00A001));
    chk("byte_en", data_route.byte_en, 2'h2);
    go('0, mk(1'b0, MMD_SZ_BYTE, 24'h00A000));
    chk("byte_en", data_route.byte_en, 2'h1);
    $display("Test concurrent and byte done");
    go('0, mk(1'b0, MMD_SZ_BIT, 24'h00FD00));
    chk("bit_ok", data_route.bit_ok, 1'b1);
    go('0, mk(1'b0, MMD_SZ_BIT, 24'h00F600));
    chk("bit_ok", data_route.bit_ok, 1'b0);
    reg_bank_access = 1'b1;
    go('0, mk(1'b0, MMD_SZ_BIT, 24'h00F600));
    chk("bit_ok", data_route.bit_ok, 1'b1);
    reg_bank_access = 1'b0;
    go('0, mk(1'b0, MMD_SZ_BIT, 24'h00F010));
    chk("bit_ok", data_route.bit_ok, 1'b1);
    $display("Test bit access done");
    wprot_size = 15'h0011;
    go('0, '0);
    go('0, mk(1'b1, MMD_SZ_WORD, 24'hE00010));
    chk("wr_blocked", data_route.wr_blocked, 1'b1);
    go('0, mk(1'b1, MMD_SZ_WORD, 24'hE00011));
    chk("wr_blocked", data_route.wr_blocked, 1'b0);
    go('0, mk(1'b1, MMD_SZ_WORD, 24'hE08010));
    chk("wr_blocked", data_route.wr_blocked, 1'b1);
    $display("Test write protect done");
    d_cmd = mk(1'b0, MMD_SZ_WORD, 24'hF00000);
    rstn = 1'b0;
    #1;
    chk("reset_valid", data_route.valid, 1'b0);
    chk("reset_trap", access_trap, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    go('0, mk(1'b0, MMD_SZ_WORD, 24'hF00000));
    chk("trap", access_trap, 1'b1);
    go('0, '0);
    $display("Test reset done");
    finish_test();
  end
endmodule : tb

bind mmd_memory_map_decoder mmd_props mmd_props_inst (.clk(clk), .rstn(rstn),
  .fetch_req(fetch_req), .data_req(data_req), .wprot_size(wprot_size),
  .reg_bank_access(reg_bank_access), .fetch_route(fetch_route), .data_route(data_route),
  .bus_to_data(bus_to_data), .bus_to_fetch(bus_to_fetch), .data_segment(data_segment),
  .data_page(data_page), .access_trap(access_trap));

// file: verilog/mmd_memory_map_decoder.sv
// Top of the memory map decoder: routes fetch and data requests to their targets.
`timescale 1ns/1ps
module mmd_memory_map_decoder
  import mmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire mmd_req_t    fetch_req,
  input  wire mmd_req_t    data_req,
  input  wire logic [14:0] wprot_size,
  input  wire logic        reg_bank_access,
  output mmd_route_t       fetch_route,
  output mmd_route_t       data_route,
  output mmd_route_t       bus_to_data,
  output mmd_route_t       bus_to_fetch,
  output logic [7:0]       data_segment,
  output logic [1:0]       data_page,
  output logic             access_trap
);

  mmd_region_t f_region;
  mmd_region_t d_region;
  logic [23:0] f_taddr;
  logic [23:0] d_taddr;
  mmd_route_t  next_f;
  mmd_route_t  next_d;
  logic [14:0] wprot;

  mmd_region_decode u_fetch_dec
  (
    .addr   (fetch_req.addr),
    .region (f_region),
    .taddr  (f_taddr)
  );

  mmd_region_decode u_data_dec
  (
    .addr   (data_req.addr),
    .region (d_region),
    .taddr  (d_taddr)
  );

  // Regions owned by the fetch unit; any other unit must cross the system bus.
  function automatic logic fetch_owned(input mmd_region_t r);
    fetch_owned = (r == MMD_RG_FLASH) || (r == MMD_RG_FLASH_RSV) ||
                  (r == MMD_RG_PROG_RAM) || (r == MMD_RG_EMU_RAM);
  endfunction : fetch_owned

  // Regions behind the external bus controller.
  function automatic logic ext_side(input mmd_region_t r);
    ext_side = (r == MMD_RG_EXT_MEM) || (r == MMD_RG_EXT_IO) ||
               (r == MMD_RG_CAN) || (r == MMD_RG_SERIAL);
  endfunction : ext_side

  function automatic logic [1:0] lanes(input mmd_size_t s, input logic a0);
    lanes = (s == MMD_SZ_WORD) ? 2'h3 : (a0 ? 2'h2 : 2'h1);
  endfunction : lanes

  // Bit addressability for a region and target offset.
  function automatic logic bit_allowed(input mmd_region_t r, input logic [23:0] a,
                                       input logic rb);
    bit_allowed = (r == MMD_RG_PRIM_REG) || (r == MMD_RG_EXTD_REG) ||
                  ((r == MMD_RG_DPORT) &&
                   (rb || ({13'h0000, a[10:0]} >= DPORT_BIT_LO - DPORT_BASE)));
  endfunction : bit_allowed

  // Builds one route from a request and its decoded region.
  function automatic mmd_route_t build(input mmd_req_t q, input mmd_region_t r,
                                       input logic [23:0] t, input logic via,
                                       input logic [14:0] wp, input logic rb);
    mmd_route_t o;
    o            = '0;
    o.valid      = q.valid;
    o.region     = r;
    o.via_bus    = via;
    o.write      = q.write;
    o.size       = q.size;
    o.bit_sel    = q.bit_sel;
    o.taddr      = t;
    o.wdata      = q.wdata;
    o.byte_en    = lanes(q.size, q.addr[0]);
    o.trap       = q.valid && (r == MMD_RG_TRAP);
    o.ordered    = (r == MMD_RG_EXT_IO);
    o.zero_read  = (r == MMD_RG_EMPTY) || (r == MMD_RG_TRAP);
    o.wr_blocked = q.write && ((r == MMD_RG_EMPTY) || (r == MMD_RG_TRAP) ||
                   (r == MMD_RG_FLASH_RSV) ||
                   (((r == MMD_RG_PROG_RAM) || (r == MMD_RG_EMU_RAM)) &&
                    (t[14:0] < wp)));
    o.bit_ok     = (q.size != MMD_SZ_BIT) || bit_allowed(r, t, rb);
    if (!o.bit_ok)
      o.wr_blocked = q.write;
    build = o;
  endfunction : build

  // Fetch side: the fetch unit serves fetches to its own memories; all other fetches are marked via_bus, but only those to external regions go onto bus_to_data.
  always_comb
  begin
    next_f = build(fetch_req, f_region, f_taddr, !fetch_owned(f_region),
                   wprot, 1'b0);
  end

  // Data side: the data unit serves data sram, registers and dual-port ram.
  always_comb
  begin
    next_d = build(data_req, d_region, d_taddr,
                   fetch_owned(d_region) || ext_side(d_region),
                   wprot, reg_bank_access);
  end

  // Protected-size setting is sampled so that a change acts on the next access.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wprot <= WPROT_RESET;
    else
      wprot <= wprot_size;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fetch_route <= '0;
      data_route  <= '0;
    end
    else
    begin
      fetch_route <= next_f;
      data_route  <= next_d;
    end
  end

  // Two independent bus lanes so both directions move in the same cycle.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bus_to_fetch <= '0;
    else
    begin
      bus_to_fetch       <= next_d;
      bus_to_fetch.valid <= next_d.valid && next_d.via_bus &&
                            fetch_owned(next_d.region);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bus_to_data <= '0;
    else
    begin
      bus_to_data       <= next_f;
      bus_to_data.valid <= next_f.valid && next_f.via_bus &&
                           ext_side(next_f.region);
    end
  end

  // Segment and page fields of the data address, and the trap pulse.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_segment <= 8'h00;
      data_page    <= 2'h0;
      access_trap  <= 1'b0;
    end
    else
    begin
      data_segment <= data_req.addr[ADDR_W-1:SEG_LSB];
      data_page    <= data_req.addr[SEG_LSB-1:PAGE_LSB];
      access_trap  <= next_f.trap || next_d.trap;
    end
  end

  // Register bank access: bit access is allowed for any dual-port ram
  // location via reg_bank_access.

endmodule : mmd_memory_map_decoder

// file: verilog/mmd_pkg.sv
// Package with address map constants, region codes and request carriers of the decoder.
package mmd_pkg;

  localparam int          ADDR_W        = 24;
  localparam int          SEG_LSB       = 16;
  localparam int          PAGE_LSB      = 14;
  localparam logic [23:0] PRIM_REG_BASE = 24'h00FE00;
  localparam logic [23:0] PRIM_REG_END  = 24'h00FFFF;
  localparam logic [23:0] DPORT_BASE    = 24'h00F600;
  localparam logic [23:0] DPORT_END     = 24'h00FDFF;
  localparam logic [23:0] DPORT_BIT_LO  = 24'h00FD00;
  localparam logic [23:0] DPORT_RSV     = 24'h00F200;
  localparam logic [23:0] EXTD_REG_BASE = 24'h00F000;
  localparam logic [23:0] EXTD_REG_END  = 24'h00F1FF;
  localparam logic [23:0] XTRN_REG_BASE = 24'h00E000;
  localparam logic [23:0] XTRN_REG_END  = 24'h00EFFF;
  localparam logic [23:0] DATA_RAM_BASE = 24'h00A000;
  localparam logic [23:0] DATA_RAM_END  = 24'h00DFFF;
  localparam logic [23:0] DATA_RAM_RSV  = 24'h008000;
  localparam logic [23:0] EXT_LO_END    = 24'h007FFF;
  localparam logic [23:0] EXT_SEG1      = 24'h010000;
  localparam logic [23:0] EXT_SEG1_END  = 24'h1FFFFF;
  localparam logic [23:0] CAN_BASE      = 24'h200000;
  localparam logic [23:0] CAN_END       = 24'h203FFF;
  localparam logic [23:0] SER_BASE      = 24'h204000;
  localparam logic [23:0] SER_END       = 24'h205FFF;
  localparam logic [23:0] ALT_BASE      = 24'h208000;
  localparam logic [23:0] ALT_END       = 24'h20BFFF;
  localparam logic [23:0] ALT_SER_OFS   = 24'h002000;
  localparam logic [23:0] EXTIO_BASE    = 24'h210000;
  localparam logic [23:0] EXTIO_END     = 24'h3FFFFF;
  localparam logic [23:0] EXTMEM_BASE   = 24'h400000;
  localparam logic [23:0] EXTMEM_END    = 24'hBFFFFF;
  localparam logic [23:0] FLASH_BASE    = 24'hC00000;
  localparam logic [23:0] FLASH_END     = 24'hCCFFFF;
  localparam logic [23:0] FLASH_RSV_LO  = 24'hC0F000;
  localparam logic [23:0] FLASH_RSV_HI  = 24'hC0FFFF;
  localparam logic [23:0] PROG_RAM_BASE = 24'hE00000;
  localparam logic [23:0] PROG_RAM_END  = 24'hE7FFFF;
  localparam logic [23:0] EMU_RAM_BASE  = 24'hE80000;
  localparam logic [23:0] EMU_RAM_END   = 24'hEFFFFF;
  localparam logic [23:0] TRAP_BASE     = 24'hF00000;
  localparam logic [23:0] TRAP_END      = 24'hFFFEFF;
  localparam logic [23:0] PBUS_BASE     = 24'hFFFF00;
  localparam logic [23:0] PBUS_END      = 24'hFFFFFF;
  localparam logic [14:0] PROG_RAM_MASK = 15'h7FFF;
  localparam logic [13:0] DATA_RAM_MASK = 14'h3FFF;
  localparam logic [10:0] DPORT_MASK    = 11'h7FF;
  localparam logic [15:0] RD_ZERO       = 16'h0000;
  localparam logic [14:0] WPROT_RESET   = 15'h0000;

  typedef enum logic [4:0] {
    MMD_RG_EXT_MEM,
    MMD_RG_EXT_IO,
    MMD_RG_DATA_RAM,
    MMD_RG_XTRN_REG,
    MMD_RG_EXTD_REG,
    MMD_RG_DPORT,
    MMD_RG_PRIM_REG,
    MMD_RG_CAN,
    MMD_RG_SERIAL,
    MMD_RG_FLASH,
    MMD_RG_FLASH_RSV,
    MMD_RG_PROG_RAM,
    MMD_RG_EMU_RAM,
    MMD_RG_PBUS,
    MMD_RG_TRAP,
    MMD_RG_EMPTY
  } mmd_region_t;

  typedef enum logic [1:0] {
    MMD_SZ_BYTE,
    MMD_SZ_WORD,
    MMD_SZ_BIT
  } mmd_size_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    mmd_size_t   size;
    logic [3:0]  bit_sel;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mmd_req_t;

  typedef struct packed {
    logic        valid;
    mmd_region_t region;
    logic        via_bus;
    logic        write;
    logic        wr_blocked;
    logic        bit_ok;
    logic        trap;
    logic        ordered;
    logic        zero_read;
    mmd_size_t   size;
    logic [1:0]  byte_en;
    logic [3:0]  bit_sel;
    logic [23:0] taddr;
    logic [15:0] wdata;
  } mmd_route_t;

  typedef enum logic [1:0] {
    MMD_BUS_IDLE,
    MMD_BUS_BUSY
  } mmd_bus_state_t;

  localparam int          SEG_W         = ADDR_W - SEG_LSB;

endpackage : mmd_pkg

// file: verilog/mmd_region_decode.sv
// Combinational address classifier that maps one 24-bit address to exactly one region.
`timescale 1ns/1ps
module mmd_region_decode
  import mmd_pkg::*;
(
  input  wire logic [23:0] addr,
  output mmd_region_t      region,
  output logic [23:0]      taddr
);

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // Priority order makes every address land in exactly one region.
  always_comb
  begin
    region = MMD_RG_EMPTY;
    taddr  = addr;
    if (in_rng(addr, PBUS_BASE, PBUS_END))
      region = MMD_RG_PBUS;
    else if (in_rng(addr, TRAP_BASE, TRAP_END))
      region = MMD_RG_TRAP;
    else if (in_rng(addr, EMU_RAM_BASE, EMU_RAM_END))
    begin
      region = MMD_RG_EMU_RAM;
      taddr  = {9'h000, addr[14:0] & PROG_RAM_MASK};
    end
    else if (in_rng(addr, PROG_RAM_BASE, PROG_RAM_END))
    begin
      region = MMD_RG_PROG_RAM;
      taddr  = {9'h000, addr[14:0] & PROG_RAM_MASK};
    end
    else if (in_rng(addr, FLASH_RSV_LO, FLASH_RSV_HI))
      region = MMD_RG_FLASH_RSV;
    else if (in_rng(addr, FLASH_BASE, FLASH_END))
      region = MMD_RG_FLASH;
    else if (in_rng(addr, EXTMEM_BASE, EXTMEM_END))
      region = MMD_RG_EXT_MEM;
    else if (in_rng(addr, EXTIO_BASE, EXTIO_END))
      region = MMD_RG_EXT_IO;
    else if (in_rng(addr, ALT_BASE, ALT_END))
    begin
      // The lower part of the alternate window reaches CAN, the upper part the serial channels.
      if (addr < ALT_BASE + ALT_SER_OFS)
      begin
        region = MMD_RG_CAN;
        taddr  = addr - ALT_BASE + CAN_BASE;
      end
      else
      begin
        region = MMD_RG_SERIAL;
        taddr  = addr - ALT_BASE - ALT_SER_OFS + SER_BASE;
      end
    end
    else if (in_rng(addr, SER_BASE, SER_END))
      region = MMD_RG_SERIAL;
    else if (in_rng(addr, CAN_BASE, CAN_END))
      region = MMD_RG_CAN;
    else if (in_rng(addr, EXT_SEG1, EXT_SEG1_END))
      region = MMD_RG_EXT_MEM;
    else if (in_rng(addr, PRIM_REG_BASE, PRIM_REG_END))
      region = MMD_RG_PRIM_REG;
    else if (in_rng(addr, DPORT_BASE, DPORT_END))
    begin
      region = MMD_RG_DPORT;
      taddr  = {13'h0000, addr[10:0] - DPORT_BASE[10:0]};
    end
    else if (in_rng(addr, EXTD_REG_BASE, EXTD_REG_END))
      region = MMD_RG_EXTD_REG;
    else if (in_rng(addr, XTRN_REG_BASE, XTRN_REG_END))
      region = MMD_RG_XTRN_REG;
    else if (in_rng(addr, DATA_RAM_BASE, DATA_RAM_END))
    begin
      region = MMD_RG_DATA_RAM;
      taddr  = {10'h000, (addr[13:0] - DATA_RAM_BASE[13:0]) & DATA_RAM_MASK};
    end
    else if (addr <= EXT_LO_END)
      region = MMD_RG_EXT_MEM;
  end

endmodule : mmd_region_decode
